/* design/rtcw_pkg.sv */
package rtcw_pkg;
	// byte addresses inside the clock register page
	localparam logic [18:0] ADDR_FLAGS  = 19'h7fff0;
	localparam logic [18:0] ADDR_CENT   = 19'h7fff1;
	localparam logic [18:0] ADDR_ASEC   = 19'h7fff2;
	localparam logic [18:0] ADDR_AMIN   = 19'h7fff3;
	localparam logic [18:0] ADDR_AHOUR  = 19'h7fff4;
	localparam logic [18:0] ADDR_ADATE  = 19'h7fff5;
	localparam logic [18:0] ADDR_IRQCTL = 19'h7fff6;
	localparam logic [18:0] ADDR_WDCTL  = 19'h7fff7;
	// event_flags fields
	localparam int FLG_WDF  = 7;
	localparam int FLG_AF   = 6;
	localparam int FLG_PF   = 5;
	localparam int FLG_OSCILLATOR_FAILED_FLAG = 4;
	localparam int FLG_CAL  = 2;
	localparam int FLG_W    = 1;
	localparam int FLG_R    = 0;
	// interrupt_control fields
	localparam int IC_WIE = 7;
	localparam int IC_AIE = 6;
	localparam int IC_PFE = 5;
	localparam int IC_HL  = 3;
	localparam int IC_PL  = 2;
	// watchdog_control fields
	localparam int WD_STROBE = 7;
	localparam int WD_GUARD  = 6;
	// alarm mask bit
	localparam int ALM_MASK = 7;
	// reset values
	localparam logic [7:0] FLAGS_RST  = 8'h00;
	localparam logic [7:0] IRQCTL_RST = 8'h08;
	localparam logic [7:0] WDCTL_RST  = 8'h00;
	localparam logic [7:0] ALARM_RST  = 8'h80;
	// timing
	localparam longint CLK_HZ        = 25000000;
	localparam longint TEST_HZ       = 512;
	localparam longint TICK_HZ       = 32;
	localparam longint PULSE_MS      = 200;
	localparam longint RESTORE_US    = 20000;
	// half period of the test output toggle, rounded down
	localparam longint TEST_HALF_CYC = CLK_HZ / (2 * TEST_HZ);
	localparam longint TICK_CYC      = CLK_HZ / TICK_HZ;
	localparam longint PULSE_CYC     = CLK_HZ / 1000 * PULSE_MS;
	localparam longint RESTORE_CYC   = CLK_HZ / 1000000 * RESTORE_US;
	// bus operation codes
	typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} rtcw_op_type;
endpackage

/* design/rtcw_bus_if.sv */
interface rtcw_bus_if;
	logic        [18:0] addr;
	logic        [7:0]  wdata;
	logic               wr;
	logic               rd;
	logic        [7:0]  rdata;
	logic               rvalid;
	logic               int_out;
	logic               int_oe;
	modport device (
		input  addr,
		input  wdata,
		input  wr,
		input  rd,
		output rdata,
		output rvalid,
		output int_out,
		output int_oe
	);
	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input  rdata,
		input  rvalid,
		input  int_out,
		input  int_oe
	);
endinterface

/* design/rtcw_divider.sv */
module rtcw_divider #(
	parameter longint DIV = 2
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// control
	input  wire logic run,
	// enable pulse
	output logic      tick
);
	localparam int W = $clog2(DIV + 1);
	logic [W-1:0] cnt_r;
	initial begin
		if (DIV < 2) $error("divider ratio too small");
	end
	always_ff @(posedge clk) begin
		if (reset || !run) cnt_r <= '0;
		else if (cnt_r == W'(DIV - 1)) cnt_r <= '0;
		else cnt_r <= cnt_r + W'(1);
	end
	always_ff @(posedge clk) begin
		if (reset) tick <= 1'b0;
		else tick <= run && (cnt_r == W'(DIV - 1));
	end
endmodule // rtcw_divider

/* design/rtcw_device.sv */
// What this block does
// - cal bit toggles int at 512 Hz
// - host opens write bit before cal change
// - alarm match sets flag, irq if enabled
// - mask bit one drops field from match
// - flag read clears alarm, watchdog and power-fail flags
// - alarm writes need write bit, apply after
// - host keeps seconds mask at zero
// - watchdog counts 32 Hz ticks while oscillating
// - powerup and strobe reload watchdog counter
// - counter zero sets watchdog flag, irq if enabled
// - guard bit blocks timeout field writes
// - zero timeout disables watchdog
// - flag read clears watchdog flag and irq
// - backup supply blocks all host access
// - outside cal mode, irq needs flag and matching enable
// - pulse mode drives about 200 ms
// - level mode holds until flag read
// - flag read ends pulse early
// - no interrupts on backup supply
// - polarity one push-pull high, zero open drain
// - flags load zero except oscillator failed
// - irq valid only after restore delay
module rtcw_device #(
	parameter longint RESTORE_CYCLES = rtcw_pkg::RESTORE_CYC,
	parameter longint PULSE_CYCLES   = rtcw_pkg::PULSE_CYC,
	parameter longint TICK_CYCLES    = rtcw_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// link to host
	rtcw_bus_if.device      bus,
	// time and power status
	input  wire logic [7:0] time_sec,
	input  wire logic [7:0] time_min,
	input  wire logic [7:0] time_hour,
	input  wire logic [7:0] time_date,
	input  wire logic       osc_running,
	input  wire logic       osc_failed,
	input  wire logic       on_backup,
	input  wire logic       power_fail
);
	initial begin
		if (PULSE_CYCLES < 1 || RESTORE_CYCLES < 1) $error("count must be positive");
	end
	localparam int RW = $clog2(RESTORE_CYCLES + 1);
	localparam int PW = $clog2(PULSE_CYCLES + 1);

	logic [7:0] flags_r, irqctl_r, wdctl_r;
	logic [7:0] alarm_r [4];
	logic [7:0] alarm_live_r [4];
	logic [5:0] wd_cnt_r;
	logic       wd_zero_r;
	logic       alm_hit_r, pf_prev_r, test_r, irq_r, oe_r, pulse_r, pulse_done_r;
	logic [PW-1:0] pulse_cnt_r;
	logic [RW-1:0] restore_r;
	logic [7:0] rdata_r;
	logic       rvalid_r;
	logic       w_prev_r;

	// three-stage synchronisers for status pins
	logic [2:0] osc_s, bkp_s, pf_s, fail_s;
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_s  <= 3'h0;
			bkp_s  <= 3'h0;
			pf_s   <= 3'h0;
			fail_s <= 3'h0;
		end else begin
			osc_s  <= {osc_s[1:0], osc_running};
			bkp_s  <= {bkp_s[1:0], on_backup};
			pf_s   <= {pf_s[1:0], power_fail};
			fail_s <= {fail_s[1:0], osc_failed};
		end
	end
	logic osc_ok_r, bkp_r, pf_r, oscillator_failed_flag_r;
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_ok_r <= 1'b0;
			bkp_r    <= 1'b0;
			pf_r     <= 1'b0;
			oscillator_failed_flag_r   <= 1'b0;
		end else begin
			if (osc_s[2] == osc_s[1]) osc_ok_r <= osc_s[2];
			if (fail_s[2] == fail_s[1]) oscillator_failed_flag_r <= fail_s[2];
			if (bkp_s[2] == bkp_s[1]) bkp_r <= bkp_s[2];
			if (pf_s[2] == pf_s[1]) pf_r <= pf_s[2];
		end
	end

	wire restored = (restore_r == RW'(RESTORE_CYCLES));
	wire access_ok = restored && !bkp_r;
	wire rd_hit   = access_ok && bus.rd;
	wire wr_hit   = access_ok && bus.wr;
	wire flag_rd  = rd_hit && (bus.addr == rtcw_pkg::ADDR_FLAGS);
	wire wr_open  = flags_r[rtcw_pkg::FLG_W];
	wire wr_flags = wr_hit && (bus.addr == rtcw_pkg::ADDR_FLAGS);
	wire wr_irq   = wr_hit && (bus.addr == rtcw_pkg::ADDR_IRQCTL);
	wire wr_wd    = wr_hit && (bus.addr == rtcw_pkg::ADDR_WDCTL);
	wire alm_wr   = wr_hit && wr_open
		&& bus.addr >= rtcw_pkg::ADDR_ASEC && bus.addr <= rtcw_pkg::ADDR_ADATE;
	wire [1:0] alm_idx = 2'(bus.addr - rtcw_pkg::ADDR_ASEC);
	wire w_closed = w_prev_r && !wr_open;

	// restore delay after power-up
	always_ff @(posedge clk) begin
		if (reset) restore_r <= '0;
		else if (!restored) restore_r <= restore_r + RW'(1);
	end

	// alarm staging and live copies
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) begin
				alarm_r[i]      <= rtcw_pkg::ALARM_RST;
				alarm_live_r[i] <= rtcw_pkg::ALARM_RST;
			end
			w_prev_r <= 1'b0;
		end else begin
			w_prev_r <= wr_open;
			if (alm_wr) alarm_r[alm_idx] <= bus.wdata;
			if (w_closed) alarm_live_r <= alarm_r;
		end
	end

	// masked compare: mask set drops that field
	function automatic logic fld_ok(input logic [7:0] a, input logic [7:0] t);
		return a[rtcw_pkg::ALM_MASK] || (a[6:0] == t[6:0]);
	endfunction
	wire alm_match = fld_ok(alarm_live_r[0], time_sec) && fld_ok(alarm_live_r[1], time_min)
		&& fld_ok(alarm_live_r[2], time_hour) && fld_ok(alarm_live_r[3], time_date);
	wire alm_event = alm_match && !alm_hit_r;

	// watchdog
	logic wd_tick;
	rtcw_divider #(.DIV(TICK_CYCLES)) u_tick (
		.clk   (clk),
		.reset (reset),
		.run   (osc_ok_r),
		.tick  (wd_tick)
	);
	wire [5:0] wd_load = wdctl_r[5:0];
	wire wd_strobe = wr_wd && bus.wdata[rtcw_pkg::WD_STROBE];
	wire wd_event  = (wd_load != 6'h00) && !wd_zero_r && (wd_cnt_r == 6'h00);
	always_ff @(posedge clk) begin
		if (reset) begin
			wd_cnt_r  <= 6'h00;
			wd_zero_r <= 1'b1;
			wdctl_r   <= rtcw_pkg::WDCTL_RST;
		end else begin
			if (wr_wd && !bus.wdata[rtcw_pkg::WD_GUARD]) wdctl_r[5:0] <= bus.wdata[5:0];
			if (wr_wd) wdctl_r[rtcw_pkg::WD_GUARD] <= bus.wdata[rtcw_pkg::WD_GUARD];
			if (!restored || wd_strobe) begin
				wd_cnt_r  <= wd_load;
				wd_zero_r <= (wd_load == 6'h00); // zero load idles until a strobe
			end else if (wd_event) begin
				wd_zero_r <= 1'b1;
			end else if (wd_tick && wd_cnt_r != 6'h00) begin
				wd_cnt_r <= wd_cnt_r - 6'h01;
			end
		end
	end

	// event flags; a set in the read cycle survives
	wire pf_event = pf_r && !pf_prev_r;
	logic [7:0] flags_nxt;
	always_comb begin
		flags_nxt = flags_r;
		if (flag_rd) begin
			flags_nxt[rtcw_pkg::FLG_WDF] = 1'b0;
			flags_nxt[rtcw_pkg::FLG_AF]  = 1'b0;
			flags_nxt[rtcw_pkg::FLG_PF]  = 1'b0;
		end
		if (wr_flags) begin
			flags_nxt[rtcw_pkg::FLG_W] = bus.wdata[rtcw_pkg::FLG_W];
			flags_nxt[rtcw_pkg::FLG_R] = bus.wdata[rtcw_pkg::FLG_R];
			if (wr_open) begin
				flags_nxt[rtcw_pkg::FLG_CAL]  = bus.wdata[rtcw_pkg::FLG_CAL];
				flags_nxt[rtcw_pkg::FLG_OSCILLATOR_FAILED_FLAG] = flags_r[rtcw_pkg::FLG_OSCILLATOR_FAILED_FLAG]
					& bus.wdata[rtcw_pkg::FLG_OSCILLATOR_FAILED_FLAG];
			end
		end
		if (wd_event) flags_nxt[rtcw_pkg::FLG_WDF] = 1'b1;
		if (alm_event) flags_nxt[rtcw_pkg::FLG_AF] = 1'b1;
		if (pf_event) flags_nxt[rtcw_pkg::FLG_PF] = 1'b1;
		if (!restored) begin
			flags_nxt = rtcw_pkg::FLAGS_RST;
			flags_nxt[rtcw_pkg::FLG_OSCILLATOR_FAILED_FLAG] = oscillator_failed_flag_r;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			flags_r   <= rtcw_pkg::FLAGS_RST;
			alm_hit_r <= 1'b0;
			pf_prev_r <= 1'b0;
			irqctl_r  <= rtcw_pkg::IRQCTL_RST;
		end else begin
			flags_r   <= flags_nxt;
			alm_hit_r <= alm_match;
			pf_prev_r <= pf_r;
			if (wr_irq) irqctl_r <= bus.wdata & 8'hec;
		end
	end

	// interrupt source and driver
	wire src = (flags_r[rtcw_pkg::FLG_WDF] && irqctl_r[rtcw_pkg::IC_WIE])
		|| (flags_r[rtcw_pkg::FLG_AF] && irqctl_r[rtcw_pkg::IC_AIE])
		|| (flags_r[rtcw_pkg::FLG_PF] && irqctl_r[rtcw_pkg::IC_PFE]);
	wire pulse_mode = irqctl_r[rtcw_pkg::IC_PL];
	wire irq_ok = restored && !bkp_r;
	logic test_tick;
	rtcw_divider #(.DIV(rtcw_pkg::TEST_HALF_CYC)) u_test (
		.clk   (clk),
		.reset (reset),
		.run   (flags_r[rtcw_pkg::FLG_CAL]),
		.tick  (test_tick)
	);
	always_ff @(posedge clk) begin
		if (reset) begin
			pulse_r      <= 1'b0;
			pulse_done_r <= 1'b0;
			pulse_cnt_r  <= '0;
			test_r       <= 1'b0;
		end else begin
			if (!flags_r[rtcw_pkg::FLG_CAL]) test_r <= 1'b0;
			else if (test_tick) test_r <= !test_r;
			if (!src || flag_rd || !pulse_mode) begin
				pulse_r      <= 1'b0;
				pulse_done_r <= 1'b0;
				pulse_cnt_r  <= '0;
			end else if (!pulse_r && !pulse_done_r) begin
				pulse_r     <= 1'b1;
				pulse_cnt_r <= PW'(PULSE_CYCLES - 1);
			end else if (pulse_r && pulse_cnt_r == '0) begin
				pulse_r      <= 1'b0;
				pulse_done_r <= 1'b1;
			end else if (pulse_r) begin
				pulse_cnt_r <= pulse_cnt_r - PW'(1);
			end
		end
	end
	// level mode follows the flags, which only a read clears
	wire active = irq_ok && (flags_r[rtcw_pkg::FLG_CAL] ? test_r
		: (pulse_mode ? pulse_r : src));
	wire hi_pol = irqctl_r[rtcw_pkg::IC_HL];
	always_ff @(posedge clk) begin
		if (reset) begin
			irq_r <= 1'b0;
			oe_r  <= 1'b0;
		end else begin
			irq_r <= hi_pol ? (active && irq_ok) : 1'b0;
			oe_r  <= hi_pol ? irq_ok : active;
		end
	end

	// read data
	logic [7:0] rd_mux;
	always_comb begin
		unique case (bus.addr)
			rtcw_pkg::ADDR_FLAGS:  rd_mux = flags_r;
			rtcw_pkg::ADDR_IRQCTL: rd_mux = irqctl_r;
			rtcw_pkg::ADDR_WDCTL:  rd_mux = {1'b0, wdctl_r[6:0]};
			rtcw_pkg::ADDR_ASEC:   rd_mux = alarm_r[0];
			rtcw_pkg::ADDR_AMIN:   rd_mux = alarm_r[1];
			rtcw_pkg::ADDR_AHOUR:  rd_mux = alarm_r[2];
			rtcw_pkg::ADDR_ADATE:  rd_mux = alarm_r[3];
			default:               rd_mux = 8'h00;
		endcase
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= rd_hit;
			if (rd_hit) rdata_r <= rd_mux;
		end
	end
	assign bus.rdata   = rdata_r;
	assign bus.rvalid  = rvalid_r;
	assign bus.int_out = irq_r;
	assign bus.int_oe  = oe_r;
endmodule // rtcw_device

/* design/rtcw_host.sv */
module rtcw_host #(
	parameter longint RESTORE_CYCLES = rtcw_pkg::RESTORE_CYC
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             reset,
	// user command port
	input  wire rtcw_pkg::rtcw_op_type op,
	input  wire logic [18:0]      op_addr,
	input  wire logic [7:0]       op_wdata,
	output logic [7:0]            op_rdata,
	output logic                  op_rvalid,
	// interrupt as seen by the host
	input  wire logic             int_pin,
	output logic                  irq_seen,
	// link to device
	rtcw_bus_if.host              bus
);
	localparam int RW = $clog2(RESTORE_CYCLES + 1);
	logic [RW-1:0] wait_r;
	logic [18:0]   addr_r;
	logic [7:0]    wdata_r, rdata_r;
	logic          wr_r, rd_r, rvalid_r, seen_r;
	logic [2:0]    int_s;
	wire ready = (wait_r == RW'(RESTORE_CYCLES));
	always_ff @(posedge clk) begin
		if (reset) wait_r <= '0;
		else if (!ready) wait_r <= wait_r + RW'(1);
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			addr_r  <= 19'h00000;
			wdata_r <= 8'h00;
			wr_r    <= 1'b0;
			rd_r    <= 1'b0;
		end else begin
			addr_r  <= op_addr;
			wdata_r <= op_wdata;
			wr_r    <= op == rtcw_pkg::OP_WRITE;
			rd_r    <= op == rtcw_pkg::OP_READ;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r  <= 8'h00;
			rvalid_r <= 1'b0;
			int_s    <= 3'h0;
			seen_r   <= 1'b0;
		end else begin
			rvalid_r <= bus.rvalid;
			if (bus.rvalid) rdata_r <= bus.rdata;
			int_s <= {int_s[1:0], int_pin};
			// pin activity during the restore delay is not trusted
			if (int_s[2] == int_s[1]) seen_r <= ready && int_s[2];
		end
	end
	assign bus.addr  = addr_r;
	assign bus.wdata = wdata_r;
	assign bus.wr    = wr_r;
	assign bus.rd    = rd_r;
	assign op_rdata  = rdata_r;
	assign op_rvalid = rvalid_r;
	assign irq_seen  = seen_r;
endmodule // rtcw_host

/* tb/rtcw_bus_sva.sv */
module rtcw_bus_sva #(
	parameter longint PULSE_CYCLES = 32
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// register access
	input wire logic [18:0] addr,
	input wire logic [7:0]  wdata,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [7:0]  rdata,
	input wire logic        rvalid,
	// pin drive
	input wire logic        int_out,
	input wire logic        int_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        hl_r;
	logic        pl_r;
	logic        w_r;
	logic        cal_r;
	logic        prev_r;
	logic [15:0] act_r;
	logic [15:0] st_r;
	wire         pin_on = int_oe && (hl_r ? int_out : !int_out);
	wire         ic_wr  = wr && (addr == rtcw_pkg::ADDR_IRQCTL);
	wire         fl_wr  = wr && (addr == rtcw_pkg::ADDR_FLAGS);
	wire         fl_rd  = rd && (addr == rtcw_pkg::ADDR_FLAGS);
	// mode mirror, trusts that the host only writes once access is open
	always_ff @(posedge clk) begin
		if (reset) begin
			hl_r  <= 1'b1;
			pl_r  <= 1'b0;
			w_r   <= 1'b0;
			cal_r <= 1'b0;
		end else begin
			hl_r  <= ic_wr ? wdata[rtcw_pkg::IC_HL] : hl_r;
			pl_r  <= ic_wr ? wdata[rtcw_pkg::IC_PL] : pl_r;
			w_r   <= fl_wr ? wdata[rtcw_pkg::FLG_W] : w_r;
			cal_r <= (fl_wr && w_r) ? wdata[rtcw_pkg::FLG_CAL] : cal_r;
		end
	end
	// run lengths of an active pin and of a still test output
	always_ff @(posedge clk) begin
		prev_r <= int_out;
		act_r  <= pin_on ? act_r + 16'h0001 : 16'h0000;
		st_r   <= (!cal_r || int_out != prev_r) ? 16'h0000 : st_r + 16'h0001;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	AST_RVALID_CAUSE: assert property (rvalid |-> $past(rd))
		else $error("read data marked without a read");
	AST_RDATA_HOLD: assert property (!rvalid |-> $stable(rdata))
		else $error("read data moved between reads");
	AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=> !rvalid && !int_oe && !int_out)
		else $error("outputs active after reset");
	AST_OPEN_DRAIN: assert property ((!hl_r && int_oe) |-> !int_out)
		else $error("active low pin driven high");
	AST_PUSH_PULL: assert property ((hl_r && int_out) |-> int_oe)
		else $error("active high pin not driven");
	AST_READ_RELEASE: assert property ((fl_rd && !cal_r) |-> ##[1:3] !pin_on)
		else $error("pin still active after flag read");
	AST_PULSE_WIDTH: assert property ((pl_r && !cal_r) |-> act_r <= PULSE_CYCLES + 1)
		else $error("pulse too long");
	AST_CAL_TOGGLE: assert property (cal_r |-> st_r <= rtcw_pkg::TEST_HALF_CYC + 2)
		else $error("test output stopped toggling");
	AST_STROBE_ZERO: assert property ((rvalid && $past(addr) == rtcw_pkg::ADDR_WDCTL) |-> !rdata[7])
		else $error("strobe bit read as one");
	AST_IRQCTL_RSVD: assert property ((rvalid && $past(addr) == rtcw_pkg::ADDR_IRQCTL) |-> (rdata[4] == 1'b0 && rdata[1:0] == 2'h0))
		else $error("reserved interrupt control bits set");
	cover property (rvalid && $past(addr) == rtcw_pkg::ADDR_FLAGS);
	cover property (pin_on && pl_r);
	cover property (cal_r && int_out != prev_r);
endmodule // rtcw_bus_sva

/* tb/rtc_alarm_watchdog_interrupt_tb_top.sv */
module rtc_alarm_watchdog_interrupt_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam longint RST_CYC = 16;
	localparam longint PLS_CYC = 32;
	logic                  clk      = 1'b0;
	logic                  reset    = 1'b1;
	rtcw_pkg::rtcw_op_type op       = rtcw_pkg::OP_IDLE;
	logic [18:0]           op_addr  = 19'h00000;
	logic [7:0]            op_wdata = 8'h00;
	logic [7:0]            op_rdata;
	logic                  op_rvalid;
	logic                  irq_seen;
	logic                  int_pin;
	logic [7:0]            t_sec    = 8'h56;
	logic [7:0]            t_min    = 8'h00;
	logic [7:0]            t_hour   = 8'h07;
	logic [7:0]            t_date   = 8'h15;
	logic                  osc_run  = 1'b1;
	logic                  osc_fail = 1'b0;
	logic                  backup   = 1'b0;
	logic                  pfail    = 1'b0;
	int                    fail_count   = 0;
	int                    total_checks = 0;
	int                    cyc      = 0;
	rtcw_bus_if bus_if ();
	// pull-up on the pin when nobody drives
	assign int_pin = bus_if.int_oe ? bus_if.int_out : 1'b1;
	always #20 clk = ~clk;
	rtcw_device #(.RESTORE_CYCLES(RST_CYC), .PULSE_CYCLES(PLS_CYC), .TICK_CYCLES(8)) i_rtcw_device (
		.clk(clk), .reset(reset), .bus(bus_if), .time_sec(t_sec), .time_min(t_min),
		.time_hour(t_hour), .time_date(t_date), .osc_running(osc_run), .osc_failed(osc_fail),
		.on_backup(backup), .power_fail(pfail));
	rtcw_host #(.RESTORE_CYCLES(RST_CYC)) i_rtcw_host (
		.clk(clk), .reset(reset), .op(op), .op_addr(op_addr), .op_wdata(op_wdata),
		.op_rdata(op_rdata), .op_rvalid(op_rvalid), .int_pin(int_pin), .irq_seen(irq_seen),
		.bus(bus_if));
	rtcw_bus_sva #(.PULSE_CYCLES(PLS_CYC)) i_rtcw_bus_sva (
		.clk(clk), .reset(reset), .addr(bus_if.addr), .wdata(bus_if.wdata), .wr(bus_if.wr),
		.rd(bus_if.rd), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid),
		.int_out(bus_if.int_out), .int_oe(bus_if.int_oe));
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pin_check(input string what, input logic exp);
		check(what, {15'h0000, int_pin}, {15'h0000, exp});
	endtask
	task automatic wr(input logic [18:0] a, input logic [7:0] d);
		@(negedge clk);
		op       = rtcw_pkg::OP_WRITE;
		op_addr  = a;
		op_wdata = d;
		@(negedge clk);
		op = rtcw_pkg::OP_IDLE;
	endtask
	// answer comes three cycles after the request, eight is the bound
	task automatic rd(input logic [18:0] a, output logic [7:0] d, output logic got);
		got = 1'b0;
		d   = 8'h00;
		@(negedge clk);
		op      = rtcw_pkg::OP_READ;
		op_addr = a;
		@(negedge clk);
		op = rtcw_pkg::OP_IDLE;
		for (int i = 0; i < 8 && !got; i++) begin
			@(negedge clk);
			if (op_rvalid === 1'b1) begin
				got = 1'b1;
				d   = op_rdata;
			end
		end
	endtask
	task automatic rdc(input logic [18:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		logic       g;
		rd(a, d, g);
		check(what, {7'h00, g, d}, {8'h01, exp});
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			fail_count++;
			close_out();
		end
	end
	initial begin
		logic [7:0] d;
		logic       g;
		logic       b;
		int         n;
		repeat (3) @(negedge clk);
		reset = 1'b0;
		wait_n(4);
		pin_check("restore quiet", 1'b1);
		check("restore seen", {15'h0000, irq_seen}, 16'h0000);
		wait_n(RST_CYC + 4);
		rdc(rtcw_pkg::ADDR_IRQCTL, rtcw_pkg::IRQCTL_RST, "irqctl reset");
		rdc(rtcw_pkg::ADDR_WDCTL, rtcw_pkg::WDCTL_RST, "wdctl reset");
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h00, "flags reset");
		$display("test reset values done");
		wr(rtcw_pkg::ADDR_FLAGS, 8'h02);
		wr(rtcw_pkg::ADDR_ASEC, 8'h56);
		wr(rtcw_pkg::ADDR_AMIN, 8'h34);
		wr(rtcw_pkg::ADDR_AHOUR, 8'h80);
		wr(rtcw_pkg::ADDR_ADATE, 8'h80);
		wr(rtcw_pkg::ADDR_IRQCTL, 8'h48);
		wr(rtcw_pkg::ADDR_FLAGS, 8'h00);
		wait_n(6);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h00, "minutes differ");
		t_min = 8'h34;
		wait_n(6);
		pin_check("alarm pin", 1'b1);
		check("alarm seen", {15'h0000, irq_seen}, 16'h0001);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h40, "alarm flag");
		wait_n(3);
		pin_check("alarm pin cleared", 1'b0);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h00, "flags after read");
		$display("test alarm done");
		t_min = 8'h00;
		wr(rtcw_pkg::ADDR_IRQCTL, 8'h88);
		wr(rtcw_pkg::ADDR_WDCTL, 8'h03);
		wr(rtcw_pkg::ADDR_WDCTL, 8'hc0);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h00, "watchdog counting");
		wait_n(40);
		pin_check("watchdog pin", 1'b1);
		rdc(rtcw_pkg::ADDR_WDCTL, 8'h43, "guarded timeout");
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h80, "watchdog flag");
		wait_n(3);
		pin_check("watchdog pin cleared", 1'b0);
		osc_run = 1'b0;
		wr(rtcw_pkg::ADDR_WDCTL, 8'h83);
		wait_n(60);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h00, "watchdog stalled");
		osc_run = 1'b1;
		wait_n(60);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h80, "watchdog resumed");
		wr(rtcw_pkg::ADDR_WDCTL, 8'h80);
		wait_n(60);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h00, "watchdog off");
		$display("test watchdog done");
		wr(rtcw_pkg::ADDR_IRQCTL, 8'h2c);
		pfail = 1'b1;
		n     = 0;
		for (int i = 0; i < 80; i++) begin
			@(negedge clk);
			n += (int_pin === 1'b1);
		end
		check("pulse width", {15'h0000, n >= PLS_CYC - 1 && n <= PLS_CYC + 1}, 16'h0001);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h20, "powerfail flag");
		pfail = 1'b0;
		wait_n(8);
		pfail = 1'b1;
		wait_n(8);
		pin_check("pulse on", 1'b1);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h20, "powerfail again");
		wait_n(2);
		pin_check("pulse cut", 1'b0);
		$display("test pulse done");
		wr(rtcw_pkg::ADDR_IRQCTL, 8'h20);
		pfail = 1'b0;
		wait_n(8);
		pfail = 1'b1;
		wait_n(8);
		pin_check("active low", 1'b0);
		check("drain enabled", {15'h0000, bus_if.int_oe}, 16'h0001);
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h20, "powerfail low");
		wait_n(3);
		pin_check("released", 1'b1);
		$display("test open drain done");
		backup = 1'b1;
		pfail  = 1'b0;
		wait_n(8);
		pfail = 1'b1;
		wait_n(8);
		pin_check("quiet on backup", 1'b1);
		rd(rtcw_pkg::ADDR_FLAGS, d, g);
		check("backup read", {15'h0000, g}, 16'h0000);
		backup = 1'b0;
		pfail  = 1'b0;
		wait_n(8);
		// the refused read must not have cleared the flag
		rdc(rtcw_pkg::ADDR_FLAGS, 8'h20, "flag kept on backup");
		$display("test backup done");
		wr(rtcw_pkg::ADDR_IRQCTL, 8'h08);
		wr(rtcw_pkg::ADDR_FLAGS, 8'h02);
		wr(rtcw_pkg::ADDR_FLAGS, 8'h06);
		wr(rtcw_pkg::ADDR_FLAGS, 8'h04);
		// first pass lands on an edge, second measures a full half period
		for (int k = 0; k < 2; k++) begin
			b = int_pin;
			n = 0;
			while (int_pin === b && n < 30000) begin
				@(negedge clk);
				n++;
			end
		end
		check("test half period", {15'h0000, n >= rtcw_pkg::TEST_HALF_CYC - 2
			&& n <= rtcw_pkg::TEST_HALF_CYC + 2}, 16'h0001);
		$display("test calibration done");
		close_out();
	end
endmodule // rtc_alarm_watchdog_interrupt_tb_top
